// *** bench/swdl_monitor.sv ***
// assertions on the shared debug pin
`timescale 1ns/1ps
`default_nettype none
module swdl_monitor import swdl_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// pin drivers
	input wire logic targetOut,
	input wire logic targetOe,
	input wire logic hostOut,
	input wire logic hostOe,
	input wire logic debugPin
);
	logic tLow, tHigh, hLow, pin_reg;
	logic [15:0] tLen_reg, hLen_reg, age_reg;
	assign tLow = targetOe && !targetOut;
	assign tHigh = targetOe && targetOut;
	assign hLow = hostOe && !hostOut;
	// run lengths of low drive, cycles since last pin fall
	always_ff @(posedge clk) begin
		pin_reg <= debugPin;
		tLen_reg <= tLow ? tLen_reg + 16'h0001 : 16'h0000;
		hLen_reg <= hLow ? hLen_reg + 16'h0001 : 16'h0000;
		if (!reset_n) begin
			age_reg <= 16'hFFFF;
		end else if (pin_reg && !debugPin) begin
			age_reg <= 16'h0000;
		end else if (age_reg != 16'hFFFF) begin
			age_reg <= age_reg + 16'h0001;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_reset_idle; disable iff (1'b0) !reset_n |=> !targetOe && !hostOe; endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("pin driven in reset");
	property p_zero_len; $fell(tLow) |-> tLen_reg == ZERO_LOW_CYCLES || tLen_reg == SYNC_PULSE_CYCLES; endproperty
	a_zero_len: assert property (p_zero_len) else $error("target low run length wrong");
	property p_zero_speedup; $fell(tLow) && tLen_reg == ZERO_LOW_CYCLES |-> tHigh; endproperty
	a_zero_speedup: assert property (p_zero_speedup) else $error("no speedup after zero");
	property p_brief_high; $rose(tHigh) |-> ##[1:2] !tHigh; endproperty
	a_brief_high: assert property (p_brief_high) else $error("speedup pulse too long");
	property p_one_release; tHigh |-> !hLow; endproperty
	a_one_release: assert property (p_one_release) else $error("speedup against host low");
	property p_no_clash; hostOe && hostOut |-> !tLow; endproperty
	a_no_clash: assert property (p_no_clash) else $error("target drives while host drives");
	property p_host_start; $rose(hLow) |-> hLow [*2]; endproperty
	a_host_start: assert property (p_host_start) else $error("host start pulse short");
	property p_host_len; $fell(hLow) |-> hLen_reg < BIT_CYCLES + 2 || hLen_reg >= SYNC_LOW_CYCLES; endproperty
	a_host_len: assert property (p_host_len) else $error("host low length wrong");
	property p_after_fall; $rose(tLow) |-> age_reg <= 16'h0005 || age_reg >= SYNC_LOW_CYCLES; endproperty
	a_after_fall: assert property (p_after_fall) else $error("target low not tied to a fall");
	c_zero_bit: cover property ($fell(tLow) && tLen_reg == ZERO_LOW_CYCLES);
	c_sync_pulse: cover property ($fell(tLow) && tLen_reg == SYNC_PULSE_CYCLES);
	c_one_bit: cover property ($rose(tHigh) && !$past(tLow));
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for both link ends
`timescale 1ns/1ps
`default_nettype none
module testbench import swdl_pkg::*;;
	localparam int TO = 200;
	logic clk = 1'b0, reset_n = 1'b0, bitValid = 1'b0, bitSend = 1'b0, bitData = 1'b0, syncReq = 1'b0;
	logic cpuHalted = 1'b0, memReady = 1'b0;
	logic [7:0] memRdata = 8'h00;
	logic bitReady, rxValid, rxBit, haltReq, goReq, stepReq, clkSel, memValid, memWrite, startHalted, cmdAbort;
	logic seenWr;
	logic [15:0] memAddr, seenAddr;
	logic [7:0] memWdata, seenData;
	int nErrors = 0, samplesChecked = 0, cycles = 0, nHalt, nGo, nStep, nAbort, nMem, syncLen;
	swdl_link_if link();
	swdl_target #(.TIMEOUT(TO)) i_swdl_target(.clk(clk), .reset_n(reset_n), .link(link), .cpuHalted(cpuHalted),
		.haltReq(haltReq), .goReq(goReq), .stepReq(stepReq), .debugClockSelect(clkSel), .memValid(memValid),
		.memReady(memReady), .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
		.startHalted(startHalted), .cmdAbort(cmdAbort));
	swdl_host i_swdl_host(.clk(clk), .reset_n(reset_n), .link(link), .bitValid(bitValid), .bitReady(bitReady),
		.bitSend(bitSend), .bitData(bitData), .syncReq(syncReq), .rxValid(rxValid), .rxBit(rxBit));
	swdl_monitor i_swdl_monitor(.clk(clk), .reset_n(reset_n), .targetOut(link.targetOut),
		.targetOe(link.targetOe), .hostOut(link.hostOut), .hostOe(link.hostOe), .debugPin(link.debugPin));
	initial begin
		forever #50 clk = ~clk;
	end
	always @(negedge clk) begin
		memReady <= ($urandom % 3) == 0;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			nErrors++;
			completeRun();
		end
		nHalt <= nHalt + haltReq;
		nGo <= nGo + goReq;
		nStep <= nStep + stepReq;
		nAbort <= nAbort + cmdAbort;
		syncLen <= syncLen + (link.targetOe && !link.targetOut);
		if (memValid && memReady) begin
			nMem <= nMem + 1;
			seenAddr <= memAddr;
			seenData <= memWdata;
			seenWr <= memWrite;
		end
	end
	function automatic logic [7:0] statusExp(logic halted, logic sel);
		return {1'b0, halted, 3'b000, sel, 2'b00};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nErrors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic clearCounts();
		{nHalt, nGo, nStep, nAbort, nMem, syncLen} = '0;
	endtask
	task automatic xfer(input logic send, input logic d, output logic r);
		int k;
		@(negedge clk);
		bitValid = 1'b1;
		bitSend = send;
		bitData = d;
		for (k = 0; k < 100 && bitReady !== 1'b1; k++) @(negedge clk);
		@(negedge clk);
		bitValid = 1'b0;
		for (k = 0; k < 20 && !send && rxValid !== 1'b1; k++) @(negedge clk);
		r = rxBit;
	endtask
	task automatic sendBits(input logic [15:0] v, input int n);
		logic r;
		for (int i = n - 1; i >= 0; i--) xfer(1'b1, v[i], r);
	endtask
	task automatic getByte(output logic [7:0] v);
		logic r;
		for (int i = 0; i < 8; i++) begin
			xfer(1'b0, 1'b1, r);
			v = {v[6:0], r};
		end
	endtask
	task automatic completeRun();
		if (nErrors == 0 && samplesChecked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		logic [7:0] v, d, c;
		logic [7:0] codes [3];
		logic [15:0] a;
		codes = '{CMD_GO, CMD_STEP, CMD_BACKGROUND};
		void'($urandom(32'h77e009e9));
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		check(16'(startHalted), 16'h0000);
		for (int h = 0; h < 2; h++) begin
			foreach (codes[j]) begin
				c = codes[j];
				cpuHalted = h[0];
				clearCounts();
				sendBits(16'(c), CMD_BITS);
				repeat (20) @(negedge clk);
				check(16'(nGo), 16'(c == CMD_GO && h == 1));
				check(16'(nStep), 16'(c == CMD_STEP && h == 1));
				check(16'(nHalt), 16'(c == CMD_BACKGROUND));
				check(16'(nAbort), 16'(c != CMD_BACKGROUND && h == 0));
			end
		end
		for (int i = 0; i < 4; i++) begin
			cpuHalted = i[0];
			d = 8'($urandom);
			d[CTRL_CLKSEL_BIT] = i[1];
			sendBits(16'(CMD_WRITE_CONTROL), 8);
			sendBits(16'(d), 8);
			repeat (20) @(negedge clk);
			check(16'(clkSel), 16'(d[CTRL_CLKSEL_BIT]));
			sendBits(16'(CMD_READ_STATUS), 8);
			getByte(v);
			check(16'(v & 8'h44), 16'(statusExp(i[0], i[1])));
			a = 16'($urandom);
			d = 8'($urandom);
			sendBits(16'(CMD_WRITE_BYTE), 8);
			sendBits(a, 16);
			sendBits(16'(d), 8);
			repeat (30) @(negedge clk);
			check(seenAddr, a);
			check(16'({seenWr, seenData}), 16'({1'b1, d}));
			memRdata = 8'($urandom);
			sendBits(16'(CMD_READ_BYTE), 8);
			sendBits(~a, 16);
			repeat (16) @(negedge clk);
			getByte(v);
			check(16'(v), 16'(memRdata));
			check(16'(seenWr), 16'h0000);
			check(seenAddr, ~a);
		end
		clearCounts();
		sendBits(16'(CMD_WRITE_BYTE), 8);
		sendBits(a, 16);
		sendBits(16'h0005, 4);
		repeat (TO + 40) @(negedge clk);
		check(16'(nAbort), 16'h0001);
		check(16'(nMem), 16'h0000);
		clearCounts();
		cpuHalted = 1'b1;
		sendBits(16'(CMD_GO), 8);
		repeat (20) @(negedge clk);
		check(16'(nGo), 16'h0001);
		clearCounts();
		syncReq = 1'b1;
		@(negedge clk);
		syncReq = 1'b0;
		repeat (450) @(negedge clk);
		check(16'(syncLen), 16'(SYNC_PULSE_CYCLES));
		completeRun();
	end
endmodule
`default_nettype wire

// *** hw/swdl_host.sv ***
// pod end of the single-wire debug link
`timescale 1ns/1ps
`default_nettype none
module swdl_host import swdl_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// link
	swdl_link_if.host link,
	// user side
	input wire logic bitValid,
	output logic bitReady,
	input wire logic bitSend,
	input wire logic bitData,
	input wire logic syncReq,
	output logic rxValid,
	output logic rxBit
);
	typedef enum {IDLE, SEND, RECV, SYNC} swdl_hstate_t;
	swdl_hstate_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic data_reg, data_next, rx_reg, rx_next, rv_reg, rv_next;
	logic oe_reg, oe_next, out_reg, out_next;
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg + 1'b1;
		data_next = data_reg;
		rx_next = rx_reg;
		rv_next = 1'b0;
		oe_next = 1'b0;
		out_next = 1'b1;
		case (state_reg)
			IDLE: begin
				cnt_next = '0;
				if (syncReq) state_next = SYNC;
				else if (bitValid) begin
					state_next = bitSend ? SEND : RECV;
					data_next = bitData;
				end
			end
			SEND: begin
				oe_next = 1'b1; // R7
				out_next = (cnt_reg >= CNT_W'(4) && data_reg) || cnt_reg >= CNT_W'(BIT_CYCLES); // R1 R7
				if (cnt_reg == CNT_W'(BIT_CYCLES + 1)) state_next = IDLE;
			end
			RECV: begin
				oe_next = cnt_reg < CNT_W'(HOST_LOW_CYCLES + 1); // R8 R9
				out_next = 1'b0;
				if (cnt_reg == CNT_W'(SAMPLE_CYCLES)) begin
					rx_next = link.debugPin; // R11
					rv_next = 1'b1;
				end
				if (cnt_reg == CNT_W'(BIT_CYCLES + 1)) state_next = IDLE;
			end
			SYNC: begin
				oe_next = cnt_reg <= CNT_W'(SYNC_LOW_CYCLES); // R21
				out_next = cnt_reg == CNT_W'(SYNC_LOW_CYCLES);
				if (cnt_reg == CNT_W'(SYNC_LOW_CYCLES + SYNC_PULSE_CYCLES + 8)) state_next = IDLE;
			end
			default: state_next = IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg <= IDLE;
			cnt_reg <= '0;
			data_reg <= 1'b0;
			rx_reg <= 1'b0;
			rv_reg <= 1'b0;
			oe_reg <= 1'b0;
			out_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			data_reg <= data_next;
			rx_reg <= rx_next;
			rv_reg <= rv_next;
			oe_reg <= oe_next;
			out_reg <= out_next;
		end
	end
	assign bitReady = state_reg == IDLE && !syncReq;
	assign link.hostOe = oe_reg;
	assign link.hostOut = out_reg;
	assign rxValid = rv_reg;
	assign rxBit = rx_reg;
endmodule
`default_nettype wire

// *** hw/swdl_link_if.sv ***
// pseudo-open-drain debug pin between pod and target
`timescale 1ns/1ps
`default_nettype none
interface swdl_link_if;
	logic targetOut;
	logic targetOe;
	logic hostOut;
	logic hostOe;
	logic debugPin;
	// pullup when nobody drives; low wins on conflict
	assign debugPin = (targetOe && !targetOut) || (hostOe && !hostOut) ? 1'b0 : 1'b1;
	modport target (output targetOut, output targetOe, input debugPin);
	modport host (output hostOut, output hostOe, input debugPin);
endinterface
`default_nettype wire

// *** hw/swdl_pkg.sv ***
// shared constants for the single-wire debug link
package swdl_pkg;
	localparam int BIT_CYCLES = 16;
	localparam int TIMEOUT_CYCLES = 512;
	localparam int SAMPLE_CYCLES = 10;
	localparam int SPEEDUP_ONE_CYCLE = 7;
	localparam int ZERO_LOW_CYCLES = 13;
	localparam int HOST_LOW_CYCLES = 2;
	localparam int SYNC_LOW_CYCLES = 128;
	localparam int SYNC_DETECT_CYCLES = 64;
	localparam int SYNC_PULSE_CYCLES = 128;
	localparam int CMD_BITS = 8;
	localparam int CNT_W = 10;
	localparam logic [7:0] CMD_BACKGROUND = 8'h90;
	localparam logic [7:0] CMD_GO = 8'h08;
	localparam logic [7:0] CMD_STEP = 8'h10;
	localparam logic [7:0] CMD_READ_STATUS = 8'hE4;
	localparam logic [7:0] CMD_WRITE_CONTROL = 8'hC4;
	localparam logic [7:0] CMD_READ_BYTE = 8'hE0;
	localparam logic [7:0] CMD_WRITE_BYTE = 8'hC0;
	localparam logic [7:0] HALT_MASK = 8'h80;
	localparam int CTRL_CLKSEL_BIT = 2;
	localparam int CTRL_HALTED_BIT = 6;
endpackage

// *** hw/swdl_target.sv ***
// target end of the single-wire debug link
// Overview of operation
// R1 - host falling edge starts every bit
// R2 - msb first, sixteen cycles per bit
// R3 - 512 idle cycles abort command
// R4 - control bit selects debug clock source
// R5 - sample host bit ten cycles after start
// R6 - target releases pin while host sends
// R7 - host drives high and low actively
// R8 - host start pulse at least two cycles
// R9 - one bit: speedup pulse at cycle seven
// R10 - zero bit: low thirteen cycles, then speedup
// R11 - host samples about ten cycles in
// R12 - halted commands only while halted
// R13 - non-intrusive commands run any time
// R14 - non-intrusive: memory and control access
// R15 - halted: cpu regs, step, resume; only CMD_STEP and CMD_GO are decoded here, no cpu register access
// R16 - pin level at reset picks mode
// R17 - rate probe answered with timed pulse
// R18 - link works without target reset
// R19 - no memory-map footprint, link only
// R20 - eight-bit command code first, msb first
// R21 - rate probe: host low 128 cycles
// R22 - two-stage synchroniser before edge detection
`timescale 1ns/1ps
`default_nettype none
module swdl_target import swdl_pkg::*; #(
	parameter int TIMEOUT = TIMEOUT_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// link
	swdl_link_if.target link,
	// cpu side
	input wire logic cpuHalted,
	output logic haltReq,
	output logic goReq,
	output logic stepReq,
	output logic debugClockSelect,
	// memory side
	output logic memValid,
	input wire logic memReady,
	output logic memWrite,
	output logic [15:0] memAddr,
	output logic [7:0] memWdata,
	input wire logic [7:0] memRdata,
	// status
	output logic startHalted,
	output logic cmdAbort
);
	initial assert (TIMEOUT > SYNC_PULSE_CYCLES && TIMEOUT < (1 << CNT_W)) else $error("timeout out of range");
	typedef enum {IDLE, RXBIT, TXBIT, SYNCWAIT, SYNCPULSE} swdl_state_t;
	typedef enum {CMD, ADDR, WDATA, MEM, RDATA, DONE} swdl_phase_t;
	logic pinS1_reg, pinS2_reg, pinS3_reg;
	swdl_state_t state_reg, state_next;
	swdl_phase_t phase_reg, phase_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [CNT_W-1:0] idle_reg, idle_next;
	logic [4:0] bits_reg, bits_next;
	logic [23:0] shift_reg, shift_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [7:0] ctrl_reg, ctrl_next; // R19
	logic [7:0] txData_reg, txData_next;
	logic txBit_reg, txBit_next;
	logic oe_reg, oe_next, out_reg, out_next;
	logic mv_reg, mv_next, abort_reg, abort_next;
	logic halt_reg, halt_next, go_reg, go_next, step_reg, step_next;
	logic strapDone_reg, strap_reg;
	logic fall;
	// buffer between memory read and serializer
	logic [7:0] buf0_reg, buf1_reg;
	logic [1:0] bufCnt_reg;
	logic bufPush, bufPop;
	function automatic logic isRead(input logic [7:0] c);
		return c == CMD_READ_BYTE;
	endfunction
	function automatic logic isHalted(input logic [7:0] c);
		return (c & HALT_MASK) == 8'h00;
	endfunction
	always_ff @(posedge clk) begin
		pinS1_reg <= link.debugPin; // R22
		pinS2_reg <= pinS1_reg; // R22
		pinS3_reg <= pinS2_reg;
	end
	assign fall = pinS3_reg && !pinS2_reg; // R1 R22 R18
	// strap sampled at release of reset
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			strapDone_reg <= 1'b0;
			strap_reg <= 1'b1;
		end else if (!strapDone_reg) begin
			strapDone_reg <= 1'b1;
			strap_reg <= pinS2_reg; // R16
		end
	end
	assign startHalted = !strap_reg; // R16
	assign bufPush = (phase_reg == MEM) && mv_reg && memReady && isRead(cmd_reg) && bufCnt_reg != 2'h2;
	assign bufPop = (phase_reg == RDATA) && state_reg == IDLE && bits_reg == 5'h00 && bufCnt_reg != 2'h0;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bufCnt_reg <= 2'h0;
			buf0_reg <= 8'h00;
			buf1_reg <= 8'h00;
		end else begin
			if (bufPush && !(bufPop && bufCnt_reg == 2'h0)) begin
				if (bufCnt_reg == 2'h0 || (bufPop && bufCnt_reg == 2'h1)) buf0_reg <= memRdata;
				else buf1_reg <= memRdata;
			end
			if (bufPop) buf0_reg <= (bufPush && bufCnt_reg == 2'h1) ? memRdata : buf1_reg;
			bufCnt_reg <= 2'(bufCnt_reg + {1'b0, bufPush} - {1'b0, bufPop});
		end
	end
	always_comb begin
		state_next = state_reg;
		phase_next = phase_reg;
		cnt_next = cnt_reg + 1'b1;
		idle_next = fall ? '0 : ((idle_reg == CNT_W'(TIMEOUT)) ? idle_reg : idle_reg + 1'b1);
		bits_next = bits_reg;
		shift_next = shift_reg;
		cmd_next = cmd_reg;
		ctrl_next = ctrl_reg;
		ctrl_next[CTRL_HALTED_BIT] = cpuHalted;
		txData_next = txData_reg;
		txBit_next = txBit_reg;
		oe_next = 1'b0; // R6
		out_next = 1'b1;
		mv_next = mv_reg;
		abort_next = 1'b0;
		halt_next = 1'b0;
		go_next = 1'b0;
		step_next = 1'b0;
		if (bufPop) begin
			txData_next = buf0_reg;
			bits_next = 5'(CMD_BITS);
		end
		case (state_reg)
			IDLE: begin
				if (fall) begin
					cnt_next = '0;
					state_next = (phase_reg == RDATA && bits_reg != 0) ? TXBIT : RXBIT;
					txBit_next = txData_reg[7]; // R2
				end
			end
			RXBIT: begin
				if (cnt_reg == CNT_W'(SAMPLE_CYCLES)) begin
					shift_next = {shift_reg[22:0], pinS2_reg}; // R5 R2
					bits_next = bits_reg - 1'b1;
				end
				if (cnt_reg == CNT_W'(SYNC_DETECT_CYCLES) && !pinS2_reg) state_next = SYNCWAIT; // R21
				else if (cnt_reg > CNT_W'(SAMPLE_CYCLES) && pinS2_reg) state_next = IDLE;
			end
			TXBIT: begin
				if (!txBit_reg && cnt_reg < CNT_W'(ZERO_LOW_CYCLES)) begin
					oe_next = 1'b1; // R10
					out_next = 1'b0;
				end else if (cnt_reg == CNT_W'(txBit_reg ? SPEEDUP_ONE_CYCLE : ZERO_LOW_CYCLES)) begin
					oe_next = 1'b1; // R9 R10
					out_next = 1'b1;
				end
				if (cnt_reg == CNT_W'(BIT_CYCLES - 1)) begin
					state_next = IDLE;
					txData_next = {txData_reg[6:0], 1'b0};
					bits_next = bits_reg - 1'b1;
					if (bits_reg == 5'h01) phase_next = DONE;
				end
			end
			SYNCWAIT: if (pinS2_reg) begin
				state_next = SYNCPULSE; // R17
				cnt_next = '0;
			end
			SYNCPULSE: begin
				oe_next = 1'b1; // R17
				out_next = cnt_reg == CNT_W'(SYNC_PULSE_CYCLES);
				if (cnt_reg == CNT_W'(SYNC_PULSE_CYCLES)) begin
					state_next = IDLE;
					phase_next = CMD;
					bits_next = 5'(CMD_BITS);
				end
			end
			default: state_next = IDLE;
		endcase
		// command decoding on completed fields
		if (state_reg == RXBIT && cnt_reg == CNT_W'(SAMPLE_CYCLES) && bits_reg == 5'h01) begin
			case (phase_reg)
				CMD: begin
					cmd_next = {shift_reg[6:0], pinS2_reg}; // R20
					phase_next = CMD;
					bits_next = 5'(CMD_BITS);
					if (isHalted(cmd_next) && !cpuHalted) begin
						abort_next = 1'b1; // R12
					end else case (cmd_next)
						CMD_BACKGROUND: halt_next = 1'b1;
						CMD_GO: go_next = 1'b1; // R15
						CMD_STEP: step_next = 1'b1; // R15
						CMD_WRITE_CONTROL: phase_next = WDATA; // R14
						CMD_READ_STATUS: begin
							phase_next = RDATA; // R13
							txData_next = ctrl_reg;
						end
						CMD_READ_BYTE, CMD_WRITE_BYTE: begin
							phase_next = ADDR; // R14
							bits_next = 5'h10;
						end
						default: ;
					endcase
				end
				ADDR: begin
					phase_next = isRead(cmd_reg) ? MEM : WDATA;
					mv_next = isRead(cmd_reg);
					bits_next = isRead(cmd_reg) ? 5'h00 : 5'(CMD_BITS);
				end
				WDATA: begin
					if (cmd_reg == CMD_WRITE_CONTROL) begin
						ctrl_next = {shift_reg[6:0], pinS2_reg}; // R4
						phase_next = CMD;
						bits_next = 5'(CMD_BITS);
					end else begin
						phase_next = MEM;
						mv_next = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (phase_reg == MEM && mv_reg && memReady) begin
			mv_next = 1'b0;
			phase_next = isRead(cmd_reg) ? RDATA : CMD;
			bits_next = isRead(cmd_reg) ? 5'h00 : 5'(CMD_BITS);
		end
		if (phase_reg == DONE) begin
			phase_next = CMD;
			bits_next = 5'(CMD_BITS);
		end
		if (idle_reg == CNT_W'(TIMEOUT - 1) && state_reg == IDLE && !mv_reg) begin
			abort_next = phase_reg != CMD || bits_reg != 5'(CMD_BITS); // R3
			phase_next = CMD;
			bits_next = 5'(CMD_BITS);
		end
	end
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg <= IDLE;
			phase_reg <= CMD;
			cnt_reg <= '0;
			idle_reg <= '0;
			bits_reg <= 5'(CMD_BITS);
			shift_reg <= '0;
			cmd_reg <= 8'h00;
			ctrl_reg <= 8'h00;
			txData_reg <= 8'h00;
			txBit_reg <= 1'b0;
			oe_reg <= 1'b0;
			out_reg <= 1'b1;
			mv_reg <= 1'b0;
			abort_reg <= 1'b0;
			halt_reg <= 1'b0;
			go_reg <= 1'b0;
			step_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			cnt_reg <= cnt_next;
			idle_reg <= idle_next;
			bits_reg <= bits_next;
			shift_reg <= shift_next;
			cmd_reg <= cmd_next;
			ctrl_reg <= ctrl_next;
			txData_reg <= txData_next;
			txBit_reg <= txBit_next;
			oe_reg <= oe_next;
			out_reg <= out_next;
			mv_reg <= mv_next;
			abort_reg <= abort_next;
			halt_reg <= halt_next;
			go_reg <= go_next;
			step_reg <= step_next;
		end
	end
	assign link.targetOe = oe_reg;
	assign link.targetOut = out_reg;
	assign memValid = mv_reg;
	assign memWrite = !isRead(cmd_reg);
	assign memAddr = isRead(cmd_reg) ? shift_reg[15:0] : shift_reg[23:8];
	assign memWdata = shift_reg[7:0];
	assign debugClockSelect = ctrl_reg[CTRL_CLKSEL_BIT]; // R4
	assign haltReq = halt_reg;
	assign goReq = go_reg;
	assign stepReq = step_reg;
	assign cmdAbort = abort_reg;
endmodule
`default_nettype wire
